// [core/tac_pkg.sv]
package tac_pkg;
    // register byte offsets
    localparam logic [7:0] TAC_CTRL_OFS = 8'h00;
    localparam logic [7:0] TAC_CAUSE_OFS = 8'h80;
    // control register fields
    localparam int TAC_C_MST_EN = 0;
    localparam int TAC_C_TEN_BIT = 1;
    localparam int TAC_C_RESTART = 2;
    localparam int TAC_C_CLEAR = 3;
    localparam logic [2:0] TAC_CTRL_RST = 3'h0;
    // transmit_abort_cause fields
    localparam int TAC_B_SEVEN_NACK = 0;
    localparam int TAC_B_TEN_FIRST_NACK = 1;
    localparam int TAC_B_TEN_SECOND_NACK = 2;
    localparam int TAC_B_DATA_NACK = 3;
    localparam int TAC_B_GC_NACK = 4;
    localparam int TAC_B_GC_READ = 5;
    localparam int TAC_B_HS_ACKED = 6;
    localparam int TAC_B_SB_ACKED = 7;
    localparam int TAC_B_NORESTART_RD = 8;
    localparam int TAC_B_MST_DIS = 9;
    localparam int TAC_B_ARB_LOSS = 10;
    localparam int TAC_B_FIFO_FLUSH = 11;
    localparam int TAC_B_SLV_ARB = 12;
    localparam int TAC_B_SLV_RD_DONE = 13;
    localparam int TAC_B_SLV_BUS_LOSS = 14;
    localparam int TAC_B_CMD_MISUSE = 15;
    localparam logic [15:0] TAC_CAUSE_RST = 16'h0000;
    // bus framing: eight data bits, then the acknowledge slot
    localparam logic [3:0] TAC_ACK_SLOT = 4'h8;
    localparam logic [1:0] TAC_IDX_MAX = 2'h3;
    // axi responses
    localparam logic [1:0] TAC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TAC_RESP_SLVERR = 2'h2;
endpackage : tac_pkg

// [core/tac_reg_if.sv]
`timescale 1ns/1ps
interface tac_reg_if;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_hit;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    modport bus (output wr_stb, wr_addr, wr_data, rd_addr, input wr_hit, rd_data, rd_hit);
    modport regs (input wr_stb, wr_addr, wr_data, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface : tac_reg_if

// [core/tac_pin_sync.sv]
`timescale 1ns/1ps
module tac_pin_sync (
    // system
    input wire logic clock,
    input wire logic rst_n,
    // raw bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    // sampled levels and edges
    output logic scl_q,
    output logic sda_q,
    output logic scl_rise,
    output logic sda_fall,
    output logic sda_rise
);
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stable;
        logic [1:0] prev;
    } tac_sync_t;

    tac_sync_t s_r;
    tac_sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = {scl_in, sda_in};
        s_nxt.stable = s_r.meta;
        s_nxt.prev = s_r.stable;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r <= '{meta: 2'h3, stable: 2'h3, prev: 2'h3};
        end else begin
            s_r <= s_nxt;
        end
    end

    // edges come from the second and third stages only
    assign scl_q = s_r.stable[1];
    assign sda_q = s_r.stable[0];
    assign scl_rise = s_r.stable[1] & ~s_r.prev[1];
    assign sda_fall = ~s_r.stable[0] & s_r.prev[0];
    assign sda_rise = s_r.stable[0] & ~s_r.prev[0];
endmodule : tac_pin_sync

// [core/tac_axil_slave.sv]
`timescale 1ns/1ps
module tac_axil_slave import tac_pkg::*; (
    // system
    input wire logic clock,
    input wire logic rst_n,
    // write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register side
    tac_reg_if.bus rb
);
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tac_axil_t;

    tac_axil_t s_r;
    tac_axil_t s_nxt;
    logic do_write;

    // a write lands only once both halves are held and no response is pending
    assign do_write = s_r.aw_held & s_r.w_held & ~s_r.bvalid;
    assign rb.wr_stb = do_write;
    assign rb.wr_addr = s_r.aw_addr;
    // partial strobes are taken as full words; only byte 0 carries live bits
    assign rb.wr_data = wstrb[0] ? s_r.w_data : s_r.w_data;
    assign rb.rd_addr = araddr;

    always_comb begin
        s_nxt = s_r;
        if (awvalid && s_r.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = awaddr;
        end
        if (wvalid && s_r.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = wdata;
        end
        if (do_write) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = rb.wr_hit ? TAC_RESP_OKAY : TAC_RESP_SLVERR;
        end else if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rb.rd_data;
            s_nxt.rresp = rb.rd_hit ? TAC_RESP_OKAY : TAC_RESP_SLVERR;
        end else if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.awready = ~s_nxt.aw_held & ~s_nxt.bvalid;
        s_nxt.wready = ~s_nxt.w_held & ~s_nxt.bvalid;
        s_nxt.arready = ~s_nxt.rvalid;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
endmodule : tac_axil_slave

// [core/tac_capture.sv]
// Functional notes
// - 7-bit master address not acknowledged sets bit 0.
// - 10-bit master, first address byte not acknowledged sets bit 1.
// - 10-bit master, second address byte not acknowledged sets bit 2.
// - master data byte after acknowledged address not acknowledged sets bit 3.
// - general call not acknowledged by anyone sets bit 4.
// - general call followed by a queued read sets bit 5.
// - high-speed master code acknowledged sets bit 6.
// - start byte acknowledged sets bit 7.
// - 10-bit read attempted with repeated start disabled sets bit 8.
// - master operation requested while master mode disabled sets bit 9.
// - arbitration loss sets bit 10; with bit 14 it is the slave's.
// - slave read request with stale transmit data sets bit 11, interrupts, flushes.
// - slave transmitter arbitration loss sets bit 12.
// - completed slave read transfer sets bit 13.
// - slave losing the bus while transmitting sets bit 14 together with 12.
// - read command written while serving a remote read sets bit 15.
`timescale 1ns/1ps
module tac_capture import tac_pkg::*; (
    // system
    input wire logic clock,
    input wire logic rst_n,
    // bus pins, observed only
    input wire logic scl_in,
    input wire logic sda_in,
    // engine context, same clock
    input wire logic eng_master,
    input wire logic eng_gen_call,
    input wire logic eng_start_byte,
    input wire logic eng_hs_code,
    input wire logic eng_slave_tx,
    input wire logic eng_send_one,
    input wire logic cmd_stb,
    input wire logic cmd_read,
    input wire logic slave_rd_req,
    input wire logic tx_fifo_has_data,
    input wire logic data_cmd_wr,
    input wire logic abort_clear,
    // engine outputs
    output logic tx_abort_interrupt,
    output logic tx_fifo_flush,
    output logic master_enable,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        logic [15:0] cause;
        logic [2:0] ctrl;
        logic in_frame;
        logic [3:0] bit_cnt;
        logic [1:0] byte_idx;
        logic flush;
        logic irq;
    } tac_cap_t;

    tac_cap_t s_r;
    tac_cap_t s_nxt;
    tac_reg_if rb ();
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic sda_fall;
    logic sda_rise;
    logic [15:0] set_v;
    logic clr_all;
    logic ack_slot;
    logic nack;
    logic ten;
    logic arb_lost;

    tac_pin_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_q(scl_q),
        .sda_q(sda_q),
        .scl_rise(scl_rise),
        .sda_fall(sda_fall),
        .sda_rise(sda_rise)
    );

    tac_axil_slave u_axil (
        .clock(clock),
        .rst_n(rst_n),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .rb(rb)
    );

    assign ten = s_r.ctrl[TAC_C_TEN_BIT];
    assign ack_slot = s_r.in_frame & scl_rise & (s_r.bit_cnt == TAC_ACK_SLOT);
    assign nack = sda_q;
    // we released sda for a one but someone pulled it low: bus lost
    assign arb_lost = s_r.in_frame & scl_rise & (s_r.bit_cnt != TAC_ACK_SLOT)
                    & eng_send_one & ~sda_q;

    // the cause register ignores writes but still answers okay
    assign rb.wr_hit = (rb.wr_addr == TAC_CTRL_OFS) | (rb.wr_addr == TAC_CAUSE_OFS);

    always_comb begin
        rb.rd_hit = 1'b1;
        case (rb.rd_addr)
            TAC_CTRL_OFS: rb.rd_data = {29'h0000000, s_r.ctrl};
            TAC_CAUSE_OFS: rb.rd_data = {16'h0000, s_r.cause};
            default: begin
                rb.rd_data = 32'h00000000;
                rb.rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        set_v = 16'h0000;
        if (ack_slot && eng_master) begin
            if (s_r.byte_idx == 2'h0) begin
                if (eng_hs_code && !nack) begin
                    set_v[TAC_B_HS_ACKED] = 1'b1;
                end else if (eng_start_byte && !nack) begin
                    set_v[TAC_B_SB_ACKED] = 1'b1;
                end else if (eng_gen_call && nack) begin
                    set_v[TAC_B_GC_NACK] = 1'b1;
                end else if (nack && ten) begin
                    set_v[TAC_B_TEN_FIRST_NACK] = 1'b1;
                end else if (nack && !eng_hs_code && !eng_start_byte) begin
                    set_v[TAC_B_SEVEN_NACK] = 1'b1;
                end
            end else if (s_r.byte_idx == 2'h1 && ten && nack) begin
                set_v[TAC_B_TEN_SECOND_NACK] = 1'b1;
            end else if (nack) begin
                set_v[TAC_B_DATA_NACK] = 1'b1;
            end
        end
        // a remote master ends its read by not acknowledging our last byte
        if (ack_slot && eng_slave_tx && nack) begin
            set_v[TAC_B_SLV_RD_DONE] = 1'b1;
        end
        if (arb_lost) begin
            set_v[TAC_B_ARB_LOSS] = 1'b1;
            if (eng_slave_tx) begin
                set_v[TAC_B_SLV_ARB] = 1'b1;
                set_v[TAC_B_SLV_BUS_LOSS] = 1'b1;
            end
        end
        if (cmd_stb) begin
            if (!s_r.ctrl[TAC_C_MST_EN]) begin
                set_v[TAC_B_MST_DIS] = 1'b1;
            end else if (eng_gen_call && cmd_read) begin
                set_v[TAC_B_GC_READ] = 1'b1;
            end else if (ten && cmd_read && !s_r.ctrl[TAC_C_RESTART]) begin
                set_v[TAC_B_NORESTART_RD] = 1'b1;
            end
        end
        if (slave_rd_req && tx_fifo_has_data) begin
            set_v[TAC_B_FIFO_FLUSH] = 1'b1;
        end
        if (data_cmd_wr && eng_slave_tx) begin
            set_v[TAC_B_CMD_MISUSE] = 1'b1;
        end
    end

    always_comb begin
        s_nxt = s_r;
        clr_all = abort_clear;
        s_nxt.flush = slave_rd_req & tx_fifo_has_data;
        if (rb.wr_stb && rb.wr_addr == TAC_CTRL_OFS) begin
            s_nxt.ctrl = rb.wr_data[2:0];
            clr_all = clr_all | rb.wr_data[TAC_C_CLEAR];
        end
        // a cause raised in the clearing cycle survives the clear
        s_nxt.cause = (clr_all ? TAC_CAUSE_RST : s_r.cause) | set_v;
        s_nxt.irq = |s_nxt.cause;
        if (sda_fall && scl_q) begin
            s_nxt.in_frame = 1'b1;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.byte_idx = 2'h0;
        end else if (sda_rise && scl_q) begin
            s_nxt.in_frame = 1'b0;
        end else if (s_r.in_frame && scl_rise) begin
            if (s_r.bit_cnt == TAC_ACK_SLOT) begin
                s_nxt.bit_cnt = 4'h0;
                if (s_r.byte_idx != TAC_IDX_MAX) begin
                    s_nxt.byte_idx = s_r.byte_idx + 2'h1;
                end
            end else begin
                s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r <= '{cause: TAC_CAUSE_RST, ctrl: TAC_CTRL_RST, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_abort_interrupt = s_r.irq;
    assign tx_fifo_flush = s_r.flush;
    assign master_enable = s_r.ctrl[TAC_C_MST_EN];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    seven_nack_a: assert property (
        ack_slot && eng_master && s_r.byte_idx == 2'h0 && nack && !ten
        && !eng_gen_call && !eng_hs_code && !eng_start_byte
        |=> s_r.cause[TAC_B_SEVEN_NACK] && !s_r.cause[TAC_B_TEN_FIRST_NACK])
        else $error("seven bit address nack not flagged");
    ten_first_a: assert property (
        ack_slot && eng_master && s_r.byte_idx == 2'h0 && nack && ten
        && !eng_gen_call && !eng_hs_code && !eng_start_byte
        |=> s_r.cause[TAC_B_TEN_FIRST_NACK])
        else $error("first ten bit byte nack not flagged");
    ten_second_a: assert property (
        ack_slot && eng_master && s_r.byte_idx == 2'h1 && nack && ten
        |=> s_r.cause[TAC_B_TEN_SECOND_NACK])
        else $error("second ten bit byte nack not flagged");
    data_nack_a: assert property (
        ack_slot && eng_master && s_r.byte_idx == 2'h2 && nack
        |=> s_r.cause[TAC_B_DATA_NACK])
        else $error("data nack not flagged");
    master_dis_a: assert property (
        cmd_stb && !master_enable |=> s_r.cause[TAC_B_MST_DIS])
        else $error("disabled master start not flagged");
    slave_loss_a: assert property (
        arb_lost && eng_slave_tx
        |=> s_r.cause[TAC_B_SLV_BUS_LOSS] && s_r.cause[TAC_B_SLV_ARB]
            && s_r.cause[TAC_B_ARB_LOSS])
        else $error("slave bus loss flags incomplete");
    bus_loss_pair_a: assert property (
        $rose(s_r.cause[TAC_B_SLV_BUS_LOSS]) |-> $rose(s_r.cause[TAC_B_SLV_ARB])
            || $past(s_r.cause[TAC_B_SLV_ARB]))
        else $error("bus loss without slave arbitration flag");
    flush_irq_a: assert property (
        slave_rd_req && tx_fifo_has_data
        |=> tx_fifo_flush && s_r.cause[TAC_B_FIFO_FLUSH] && tx_abort_interrupt)
        else $error("stale fifo flush sequence missing");
    flush_pulse_a: assert property (
        tx_fifo_flush |=> !tx_fifo_flush || $past(slave_rd_req))
        else $error("flush held without request");
    sticky_cause_a: assert property (
        !abort_clear && !rb.wr_stb |=> (s_r.cause & $past(s_r.cause)) == $past(s_r.cause))
        else $error("cause flag dropped without clear");
    upper_zero_a: assert property (
        s_axi_rvalid && $past(s_axi_araddr) == TAC_CAUSE_OFS && $past(s_axi_arvalid)
        |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper cause bits not zero");
    misuse_a: assert property (
        data_cmd_wr && eng_slave_tx |=> s_r.cause[TAC_B_CMD_MISUSE])
        else $error("read command misuse not flagged");
    gc_nack_a: assert property (
        ack_slot && eng_master && s_r.byte_idx == 2'h0 && nack && eng_gen_call
        && !eng_hs_code && !eng_start_byte |=> s_r.cause[TAC_B_GC_NACK])
        else $error("general call nack not flagged");
    hs_acked_a: assert property (
        ack_slot && eng_master && s_r.byte_idx == 2'h0 && !nack && eng_hs_code
        |=> s_r.cause[TAC_B_HS_ACKED])
        else $error("high speed code ack not flagged");
    sb_acked_a: assert property (
        ack_slot && eng_master && s_r.byte_idx == 2'h0 && !nack && eng_start_byte
        && !eng_hs_code |=> s_r.cause[TAC_B_SB_ACKED])
        else $error("start byte ack not flagged");
    gc_read_a: assert property (
        cmd_stb && master_enable && eng_gen_call && cmd_read
        |=> s_r.cause[TAC_B_GC_READ])
        else $error("general call read not flagged");
    no_restart_a: assert property (
        cmd_stb && master_enable && !eng_gen_call && ten && cmd_read
        && !s_r.ctrl[TAC_C_RESTART] |=> s_r.cause[TAC_B_NORESTART_RD])
        else $error("ten bit read without restart not flagged");
    slave_done_a: assert property (
        ack_slot && eng_slave_tx && nack |=> s_r.cause[TAC_B_SLV_RD_DONE])
        else $error("slave read done not flagged");
    arb_flag_a: assert property (
        arb_lost |=> s_r.cause[TAC_B_ARB_LOSS])
        else $error("arbitration loss not flagged");

    gc_nack_c: cover property (ack_slot && eng_gen_call && nack);
    arb_c: cover property (arb_lost ##1 s_r.cause[TAC_B_ARB_LOSS]);
    clear_c: cover property (s_r.cause != 16'h0000 ##1 abort_clear ##1 s_r.cause == 16'h0000);
endmodule : tac_capture

// [tb/tac_bus_model.sv]
`timescale 1ns/1ps
module tac_bus_model (
    // bus lines as the pull-ups leave them
    output logic scl,
    output logic sda
);
    // scl stands high between frames; a released sda reads high
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic put_bit(input logic b);
        sda = b;
        #100 scl = 1'b1;
        #200 scl = 1'b0;
        #100;
    endtask : put_bit

    // nb bytes of dat; ack[i] high means the ack slot of byte i is pulled low
    task automatic frame(input int nb, input logic [7:0] dat, input logic [3:0] ack);
        sda = 1'b0;
        #100 scl = 1'b0;
        for (int i = 0; i < nb; i++) begin
            for (int k = 7; k >= 0; k--) put_bit(dat[k]);
            put_bit(!ack[i]);
        end
        sda = 1'b0;
        #100 scl = 1'b1;
        #100 sda = 1'b1;
        #100;
    endtask : frame
endmodule : tac_bus_model

// [tb/tb_tac_capture.sv]
`timescale 1ns/1ps
module tb_tac_capture import tac_pkg::*;;
    logic clock, rst_n;
    wire scl_in, sda_in;
    logic eng_master, eng_gen_call, eng_start_byte, eng_hs_code, eng_slave_tx, eng_send_one;
    logic cmd_stb, cmd_read, slave_rd_req, tx_fifo_has_data, data_cmd_wr, abort_clear;
    logic tx_abort_interrupt, tx_fifo_flush, master_enable;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [2:0] ctrl_v;
    int bad_count, n_checks;

    tac_bus_model u_bus (.scl(scl_in), .sda(sda_in));

    tac_capture dut (.clock, .rst_n, .scl_in, .sda_in, .eng_master, .eng_gen_call,
        .eng_start_byte, .eng_hs_code, .eng_slave_tx, .eng_send_one, .cmd_stb, .cmd_read,
        .slave_rd_req, .tx_fifo_has_data, .data_cmd_wr, .abort_clear, .tx_abort_interrupt,
        .tx_fifo_flush, .master_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic lost();
        bad_count++;
        $display("[ERR] t=%0t seen=%h exp=%h wait limit", $time, 1'b0, 1'b1);
        print_verdict();
    endtask : lost

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 64 && !done; i++) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                chk({30'h0, s_axi_bresp}, {30'h0, er});
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) lost();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit done = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 64 && !done; i++) begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                chk(s_axi_rdata, ed);
                chk({30'h0, s_axi_rresp}, {30'h0, er});
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) lost();
    endtask : rd

    task automatic set_ctrl(input logic [2:0] c);
        ctrl_v = c;
        wr(TAC_CTRL_OFS, {29'h0, c}, TAC_RESP_OKAY);
    endtask : set_ctrl

    // flags: {send_one, slave_tx, hs_code, start_byte, gen_call, master}
    task automatic ctx(input logic [5:0] f);
        @(posedge clock);
        {eng_send_one, eng_slave_tx, eng_hs_code, eng_start_byte, eng_gen_call, eng_master} <= f;
    endtask : ctx

    task automatic cmd(input logic r);
        @(posedge clock);
        cmd_stb <= 1'b1;
        cmd_read <= r;
        @(posedge clock);
        cmd_stb <= 1'b0;
    endtask : cmd

    // three sync flops plus the capture edge before the flag can be read
    task automatic expect_cause(input logic [15:0] e);
        repeat (4) @(posedge clock);
        rd(TAC_CAUSE_OFS, {16'h0000, e}, TAC_RESP_OKAY);
        chk({31'h0, tx_abort_interrupt}, {31'h0, (e != 16'h0000)});
        wr(TAC_CTRL_OFS, {28'h0, 1'b1, ctrl_v}, TAC_RESP_OKAY);
        rd(TAC_CAUSE_OFS, 32'h0, TAC_RESP_OKAY);
        $display("case %h done", e);
    endtask : expect_cause

    task automatic bus(input logic [5:0] f, input logic [2:0] c, input int nb,
                       input logic [7:0] d, input logic [3:0] ack, input logic [15:0] e);
        set_ctrl(c);
        ctx(f);
        u_bus.frame(nb, d, ack);
        expect_cause(e);
        ctx(6'h00);
    endtask : bus

    initial begin
        rst_n = 1'b0;
        {eng_master, eng_gen_call, eng_start_byte, eng_hs_code, eng_slave_tx} = 5'h00;
        {eng_send_one, cmd_stb, cmd_read, slave_rd_req, tx_fifo_has_data} = 5'h00;
        {data_cmd_wr, abort_clear, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        ctrl_v = 3'h0;
        bad_count = 0;
        n_checks = 0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(TAC_CTRL_OFS, 32'h0, TAC_RESP_OKAY);
        rd(TAC_CAUSE_OFS, 32'h0, TAC_RESP_OKAY);
        rd(8'h40, 32'h0, TAC_RESP_SLVERR);
        wr(8'h40, 32'hFFFF_FFFF, TAC_RESP_SLVERR);
        wr(TAC_CAUSE_OFS, 32'hFFFF_FFFF, TAC_RESP_OKAY);
        rd(TAC_CAUSE_OFS, 32'h0, TAC_RESP_OKAY);
        $display("register access done");
        cmd(1'b0);
        repeat (3) @(posedge clock);
        abort_clear <= 1'b1;
        @(posedge clock);
        abort_clear <= 1'b0;
        rd(TAC_CAUSE_OFS, 32'h0, TAC_RESP_OKAY);
        cmd(1'b0);
        expect_cause(16'h0200);
        set_ctrl(3'h1);
        chk({31'h0, master_enable}, 32'h1);
        ctx(6'h03);
        cmd(1'b1);
        expect_cause(16'h0020);
        ctx(6'h01);
        set_ctrl(3'h3);
        cmd(1'b1);
        expect_cause(16'h0100);
        set_ctrl(3'h7);
        rd(TAC_CTRL_OFS, 32'h7, TAC_RESP_OKAY);
        cmd(1'b1);
        expect_cause(16'h0000);
        bus(6'h01, 3'h1, 1, 8'hA4, 4'h0, 16'h0001);
        bus(6'h01, 3'h3, 1, 8'hF0, 4'h0, 16'h0002);
        bus(6'h01, 3'h3, 2, 8'hF0, 4'h1, 16'h0004);
        bus(6'h01, 3'h1, 2, 8'hA4, 4'h1, 16'h0008);
        bus(6'h01, 3'h3, 3, 8'hF0, 4'h3, 16'h0008);
        bus(6'h03, 3'h1, 1, 8'h00, 4'h0, 16'h0010);
        bus(6'h09, 3'h1, 1, 8'h08, 4'h1, 16'h0040);
        bus(6'h05, 3'h1, 1, 8'h01, 4'h1, 16'h0080);
        bus(6'h21, 3'h1, 1, 8'h00, 4'h1, 16'h0400);
        bus(6'h30, 3'h1, 1, 8'h00, 4'h1, 16'h5400);
        bus(6'h10, 3'h1, 1, 8'h5A, 4'h0, 16'h2000);
        @(posedge clock);
        slave_rd_req <= 1'b1;
        tx_fifo_has_data <= 1'b1;
        @(posedge clock);
        slave_rd_req <= 1'b0;
        @(posedge clock);
        chk({31'h0, tx_fifo_flush}, 32'h1);
        @(posedge clock);
        chk({31'h0, tx_fifo_flush}, 32'h0);
        tx_fifo_has_data <= 1'b0;
        expect_cause(16'h0800);
        ctx(6'h10);
        @(posedge clock);
        data_cmd_wr <= 1'b1;
        @(posedge clock);
        data_cmd_wr <= 1'b0;
        expect_cause(16'h8000);
        print_verdict();
    end
endmodule : tb_tac_capture
